// *** hw/status_event_hierarchy.sv ***
// Status and event hierarchy: instrument structures, top structure, event register, status byte
`timescale 1ns/100ps
// Behaviour
// - Questionable structure has the same shape but every register reads zero.
// - Instrument condition bits: calibrate, settle, range, sweep, measure, trigger, arm, correct, test, abort, program.
// - Condition register follows activity continuously, bit set or cleared as it changes.
// - A rising condition bit with its positive filter set passes onward.
// - A falling condition bit with its negative filter set sets the event bit.
// - Each accepted transition sets and latches its event bit.
// - Reading an operational event register returns it and then clears it.
// - Summary is OR over all bits of event AND enable.
// - Top operational bits 1 to 14 take instrument summaries; bit 15 reads zero.
// - Top operational summary drives status byte bit 7.
// - Standard event register is eight bits, cleared on read and on clear-status.
// - Standard event bits: 0 complete, 2 query, 3 device, 4 execution, 5 command, 7 power-on.
// - Standard event register masked by its enable forms status byte bit 5.
// - Status byte bit 2 is high while the error and event queue is not empty.
// - Status byte bit 4 is high while an output message awaits reading.
// - Status byte AND service request enable forms bit 6; it raises service request.
// - Status byte clears after its read; service request enable read leaves it unchanged.
// - Preset clears operational enables, sets positive filters, clears negative filters only.
module status_event_hierarchy
    import status_event_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    input  wire logic [NUM_INSTR-1:0][OSR_W-1:0] instr_cond,
    input  wire logic [SB_W-1:0]                esr_event,
    input  wire logic                           queue_not_empty,
    input  wire logic                           message_available,
    input  wire logic                           status_preset,
    input  wire logic                           clear_status_command,
    input  wire logic                           cmd_valid,
    input  wire logic                           cmd_write,
    input  wire logic                           cmd_quest,
    input  wire logic [UNIT_W-1:0]              cmd_unit,
    input  wire reg_sel_t                       cmd_sel,
    input  wire logic [OSR_W-1:0]               cmd_wdata,
    output logic      [OSR_W-1:0]               rd_data,
    output logic                                rd_valid,
    output logic      [SB_W-1:0]                status_byte,
    output logic                                master_summary,
    output logic                                service_request
);

    // Index 0 is the top-level structure, 1..NUM_INSTR the instruments
    logic [OSR_W-1:0] cond_a   [0:NUM_INSTR];
    logic [OSR_W-1:0] event_a  [0:NUM_INSTR];
    logic [OSR_W-1:0] enable_a [0:NUM_INSTR];
    logic [OSR_W-1:0] ptr_a    [0:NUM_INSTR];
    logic [OSR_W-1:0] ntr_a    [0:NUM_INSTR];
    logic [NUM_INSTR:0] sum_a;
    logic [OSR_W-1:0] top_cond;

    logic            rd_cmd;
    logic            wr_cmd;
    logic [SB_W-1:0] esr_r;
    logic [SB_W-1:0] ese_r;
    logic [SB_W-1:0] sre_r;
    logic [SB_W-1:0] stb_r;
    logic [SB_W-1:0] stb_live;
    logic [SB_W-1:0] esr_nxt;
    logic [SB_W-1:0] stb_nxt;
    logic            por_done_r;
    logic            esr_sum;
    logic [OSR_W-1:0] rd_nxt;

    function automatic logic unit_hit(input logic [UNIT_W-1:0] unit, input int idx);
        unit_hit = (int'(unit) == idx);
    endfunction

    function automatic logic op_access(input logic quest, input reg_sel_t sel, input reg_sel_t want);
        op_access = !quest && (sel == want);
    endfunction

    assign rd_cmd = cmd_valid && !cmd_write;
    assign wr_cmd = cmd_valid && cmd_write;

    // Top structure sees the instrument summaries as its condition
    always_comb begin
        top_cond = COND_RST;
        top_cond[TOP_FIRST_BIT +: NUM_INSTR] = sum_a[NUM_INSTR:1];
    end

    genvar gi;
    generate
        for (gi = 0; gi <= NUM_INSTR; gi++) begin : g_osr
            status_structure u_osr (
                .clk       (clk),
                .reset_n   (reset_n),
                .cond_in   ((gi == 0) ? top_cond : instr_cond[(gi == 0) ? 0 : gi - 1]),
                .preset    (status_preset),
                .en_wr     (wr_cmd && unit_hit(cmd_unit, gi) && op_access(cmd_quest, cmd_sel, SEL_ENABLE)),
                .ptr_wr    (wr_cmd && unit_hit(cmd_unit, gi) && op_access(cmd_quest, cmd_sel, SEL_PTR)),
                .ntr_wr    (wr_cmd && unit_hit(cmd_unit, gi) && op_access(cmd_quest, cmd_sel, SEL_NTR)),
                .wdata     (cmd_wdata),
                .ev_rd_clr (rd_cmd && unit_hit(cmd_unit, gi) && op_access(cmd_quest, cmd_sel, SEL_EVENT)),
                .cond_r    (cond_a[gi]),
                .event_r   (event_a[gi]),
                .enable_r  (enable_a[gi]),
                .ptr_r     (ptr_a[gi]),
                .ntr_r     (ntr_a[gi]),
                .summary   (sum_a[gi])
            );
        end
    endgenerate

    // Power-on is reported once, the cycle after reset release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            por_done_r <= 1'b0;
        end else begin
            por_done_r <= 1'b1;
        end
    end

    // Standard event register: no condition stage, sets win over clears
    always_comb begin
        esr_nxt = esr_r;
        if ((rd_cmd && op_access(cmd_quest, cmd_sel, SEL_ESR)) || clear_status_command) begin
            esr_nxt = ESR_RST;
        end
        esr_nxt = esr_nxt | (esr_event & ESR_USED_MASK);
        esr_nxt[ESR_POWER_ON] = esr_nxt[ESR_POWER_ON] | !por_done_r;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            esr_r <= ESR_RST;
        end else begin
            esr_r <= esr_nxt;
        end
    end

    // Enables for the event register and service request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ese_r <= ESE_RST;
            sre_r <= SRE_RST;
        end else if (wr_cmd && !cmd_quest) begin
            if (cmd_sel == SEL_ESE) begin
                ese_r <= cmd_wdata[SB_W-1:0];
            end
            if (cmd_sel == SEL_SRE) begin
                sre_r <= cmd_wdata[SB_W-1:0];
            end
        end
    end

    assign esr_sum = |(esr_r & ese_r);

    // Live sources of the status byte; reserved positions stay low
    always_comb begin
        stb_live              = STB_RST;
        stb_live[STB_QUEUE]   = queue_not_empty;
        stb_live[STB_MAV]     = message_available;
        stb_live[STB_ESR_SUM] = esr_sum;
        stb_live[STB_OP_SUM]  = sum_a[0];
    end

    // Latched byte: a read clears it, but a source still high sets it again
    always_comb begin
        stb_nxt = stb_r;
        if (rd_cmd && op_access(cmd_quest, cmd_sel, SEL_STB)) begin
            stb_nxt = STB_RST;
        end
        stb_nxt = (stb_nxt | stb_live) & ~STB_ZERO_MASK;
        stb_nxt[STB_MSS] = 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stb_r <= STB_RST;
        end else begin
            stb_r <= stb_nxt;
        end
    end

    // Bit 6 of the enable is ignored so the summary cannot feed itself
    assign master_summary  = |(stb_r & sre_r & SRE_MSS_MASK);
    assign service_request = master_summary;

    always_comb begin
        status_byte          = stb_r;
        status_byte[STB_MSS] = master_summary;
    end

    // Read decode; questionable selections always return zero
    always_comb begin
        rd_nxt = '0;
        if (cmd_quest) begin
            rd_nxt = '0;
        end else if (cmd_sel == SEL_ESR) begin
            rd_nxt = {8'h00, esr_r};
        end else if (cmd_sel == SEL_ESE) begin
            rd_nxt = {8'h00, ese_r};
        end else if (cmd_sel == SEL_SRE) begin
            rd_nxt = {8'h00, sre_r};
        end else if (cmd_sel == SEL_STB) begin
            rd_nxt = {8'h00, status_byte};
        end else if (int'(cmd_unit) <= NUM_INSTR) begin
            case (cmd_sel)
                SEL_COND:   rd_nxt = cond_a[cmd_unit];
                SEL_EVENT:  rd_nxt = event_a[cmd_unit];
                SEL_ENABLE: rd_nxt = enable_a[cmd_unit];
                SEL_PTR:    rd_nxt = ptr_a[cmd_unit];
                SEL_NTR:    rd_nxt = ntr_a[cmd_unit];
                default:    rd_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data  <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_cmd;
            if (rd_cmd) begin
                rd_data <= rd_nxt;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    quest_reads_zero_a: assert property (rd_cmd && cmd_quest |=> rd_valid && rd_data == 16'h0000)
        else $error("questionable read not zero");

    cond_tracks_input_a: assert property (##1 cond_a[1] == ($past(instr_cond[0]) & OSR_VALID_MASK))
        else $error("condition register does not follow input");

    rise_sets_event_a: assert property (
        (!cond_a[1][COND_MEASURING] && instr_cond[0][COND_MEASURING] && ptr_a[1][COND_MEASURING] && !status_preset)
        |=> event_a[1][COND_MEASURING])
        else $error("filtered rise did not set event");

    fall_sets_event_a: assert property (
        (cond_a[1][COND_SWEEP_ACTIVE] && !instr_cond[0][COND_SWEEP_ACTIVE] && ntr_a[1][COND_SWEEP_ACTIVE])
        |=> event_a[1][COND_SWEEP_ACTIVE])
        else $error("filtered fall did not set event");

    event_latched_a: assert property (event_a[2][COND_ABORT] && !(rd_cmd && unit_hit(cmd_unit, 2)
        && op_access(cmd_quest, cmd_sel, SEL_EVENT)) |=> event_a[2][COND_ABORT])
        else $error("event bit lost without read");

    event_read_clear_a: assert property (
        rd_cmd && unit_hit(cmd_unit, 1) && op_access(cmd_quest, cmd_sel, SEL_EVENT) && cond_a[1] == instr_cond[0]
        |=> rd_data == $past(event_a[1]) && event_a[1] == 16'h0000)
        else $error("event read did not return and clear");

    summary_or_a: assert property (sum_a[3] == |(event_a[3] & enable_a[3]))
        else $error("summary mismatch");

    top_map_a: assert property (##1 cond_a[0][15] == 1'b0 && cond_a[0][14:1] == $past(sum_a[14:1]))
        else $error("top operational mapping wrong");

    stb_sources_a: assert property (sum_a[0] && queue_not_empty && message_available && esr_sum
        |=> stb_r[STB_OP_SUM] && stb_r[STB_QUEUE] && stb_r[STB_MAV] && stb_r[STB_ESR_SUM])
        else $error("status byte source not reflected");

    esr_clear_a: assert property (clear_status_command && esr_event == 8'h00 && por_done_r
        |=> esr_r == 8'h00)
        else $error("clear status left event bits");

    esr_unused_a: assert property (esr_r[1] == 1'b0 && esr_r[6] == 1'b0)
        else $error("unused standard event bit set");

    srq_raise_a: assert property (service_request == |(status_byte & sre_r & SRE_MSS_MASK)
        && status_byte[STB_MSS] == service_request)
        else $error("service request mismatch");

    sre_read_keeps_a: assert property (rd_cmd && op_access(cmd_quest, cmd_sel, SEL_SRE) |=> $stable(sre_r))
        else $error("enable changed by read");

    stb_read_clear_a: assert property (rd_cmd && op_access(cmd_quest, cmd_sel, SEL_STB) && stb_live == 8'h00
        |=> stb_r == 8'h00)
        else $error("status byte not cleared by read");

    preset_effect_a: assert property (status_preset && !wr_cmd |=> enable_a[4] == 16'h0000
        && ptr_a[4] == PTR_PRESET && ntr_a[4] == 16'h0000 && $stable(sre_r) && $stable(ese_r))
        else $error("preset effect wrong");

    enable_range_a: assert property (enable_a[5][15] == 1'b0)
        else $error("enable bit 15 set");

    stb_reserved_a: assert property ((status_byte & STB_ZERO_MASK) == 8'h00)
        else $error("reserved status byte bit set");

    event_read_cov: cover property (rd_cmd && op_access(cmd_quest, cmd_sel, SEL_EVENT) && event_a[cmd_unit] != 16'h0000);
    srq_rise_cov:   cover property ($rose(service_request));
    preset_cov:     cover property (status_preset ##1 sum_a[0] == 1'b0);

endmodule

// *** hw/status_event_pkg.sv ***
// Shared constants, register selectors and helpers for the status and event hierarchy
package status_event_pkg;

    localparam int NUM_INSTR = 14;
    localparam int UNIT_W    = 4;
    localparam int OSR_W     = 16;
    localparam int SB_W      = 8;

    // Operational structure masks and reset values
    localparam logic [15:0] OSR_VALID_MASK = 16'h7FFF;
    localparam logic [15:0] ENABLE_MASK    = 16'h7FFF;
    localparam logic [15:0] PTR_PRESET     = 16'h7FFF;
    localparam logic [15:0] NTR_PRESET     = 16'h0000;
    localparam logic [15:0] ENABLE_RST     = 16'h0000;
    localparam logic [15:0] EVENT_RST      = 16'h0000;
    localparam logic [15:0] COND_RST       = 16'h0000;

    // Instrument condition bit positions
    localparam int COND_CALIBRATION_ACTIVE = 0;
    localparam int COND_SETTLE_WAIT        = 1;
    localparam int COND_RANGE_CHANGE       = 2;
    localparam int COND_SWEEP_ACTIVE       = 3;
    localparam int COND_MEASURING          = 4;
    localparam int COND_TRIGGER_WAIT       = 5;
    localparam int COND_ARM_WAIT           = 6;
    localparam int COND_CORRECTION_ACTIVE  = 7;
    localparam int COND_SELF_TEST          = 8;
    localparam int COND_ABORT              = 9;
    localparam int COND_PROGRAM_RUNNING    = 14;

    // First top-level bit taken by an instrument summary
    localparam int TOP_FIRST_BIT = 1;

    // Standard event bit positions
    localparam int ESR_OPC        = 0;
    localparam int ESR_QUERY_ERR  = 2;
    localparam int ESR_DEVICE_ERR = 3;
    localparam int ESR_EXEC_ERR   = 4;
    localparam int ESR_CMD_ERR    = 5;
    localparam int ESR_POWER_ON   = 7;
    localparam logic [7:0] ESR_USED_MASK = 8'hBD;

    // Status byte bit positions
    localparam int STB_QUEUE   = 2;
    localparam int STB_MAV     = 4;
    localparam int STB_ESR_SUM = 5;
    localparam int STB_MSS     = 6;
    localparam int STB_OP_SUM  = 7;
    localparam logic [7:0] STB_ZERO_MASK = 8'h0B;
    localparam logic [7:0] SRE_MSS_MASK  = 8'hBF;

    localparam logic [7:0] ESR_RST = 8'h00;
    localparam logic [7:0] ESE_RST = 8'h00;
    localparam logic [7:0] SRE_RST = 8'h00;
    localparam logic [7:0] STB_RST = 8'h00;

    typedef enum logic [3:0] {
        SEL_COND, SEL_EVENT, SEL_ENABLE, SEL_PTR, SEL_NTR,
        SEL_ESR, SEL_ESE, SEL_STB, SEL_SRE
    } reg_sel_t;

    function automatic logic summary_of(input logic [15:0] ev, input logic [15:0] en);
        summary_of = |(ev & en);
    endfunction

endpackage

// *** hw/status_structure.sv ***
// One operational status structure: condition, transition filters, event, enable, summary
`timescale 1ns/100ps
module status_structure
    import status_event_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [15:0] cond_in,
    input  wire logic        preset,
    input  wire logic        en_wr,
    input  wire logic        ptr_wr,
    input  wire logic        ntr_wr,
    input  wire logic [15:0] wdata,
    input  wire logic        ev_rd_clr,
    output logic      [15:0] cond_r,
    output logic      [15:0] event_r,
    output logic      [15:0] enable_r,
    output logic      [15:0] ptr_r,
    output logic      [15:0] ntr_r,
    output logic             summary
);

    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] event_nxt;

    // Condition follows the live activity every cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cond_r <= COND_RST;
        end else begin
            cond_r <= cond_in & OSR_VALID_MASK;
        end
    end

    assign rise = (cond_in & OSR_VALID_MASK) & ~cond_r;
    assign fall = ~(cond_in & OSR_VALID_MASK) & cond_r;

    // A set arriving with the read clear survives to the next read
    always_comb begin
        event_nxt = ev_rd_clr ? EVENT_RST : event_r;
        event_nxt = event_nxt | (rise & ptr_r) | (fall & ntr_r);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            event_r <= EVENT_RST;
        end else begin
            event_r <= event_nxt;
        end
    end

    // Preset has priority over a host write in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_r <= ENABLE_RST;
            ptr_r    <= PTR_PRESET;
            ntr_r    <= NTR_PRESET;
        end else if (preset) begin
            enable_r <= ENABLE_RST;
            ptr_r    <= PTR_PRESET;
            ntr_r    <= NTR_PRESET;
        end else begin
            if (en_wr) begin
                enable_r <= wdata & ENABLE_MASK;
            end
            if (ptr_wr) begin
                ptr_r <= wdata & OSR_VALID_MASK;
            end
            if (ntr_wr) begin
                ntr_r <= wdata & OSR_VALID_MASK;
            end
        end
    end

    assign summary = summary_of(event_r, enable_r);

endmodule

// *** test/host_ctrl_model.sv ***
// Host controller model issuing register accesses on the command port
`timescale 1ns/100ps
module host_ctrl_model
    import status_event_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rd_valid,
    input  wire logic [OSR_W-1:0]  rd_data,
    output logic                   cmd_valid,
    output logic                   cmd_write,
    output logic                   cmd_quest,
    output logic [UNIT_W-1:0]      cmd_unit,
    output reg_sel_t               cmd_sel,
    output logic [OSR_W-1:0]       cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_quest = 1'b0;
        cmd_unit  = 4'h0;
        cmd_sel   = SEL_COND;
        cmd_wdata = 16'h0000;
    end

    // Fields are held from launch to the taking edge, then valid drops, write and data are shown inverted, and quest, unit and select stay stale
    task automatic access(input logic wr, input logic qst, input logic [UNIT_W-1:0] unit,
                          input reg_sel_t sel, input logic [OSR_W-1:0] wdata,
                          output logic [OSR_W-1:0] rdata, output logic ok);
        rdata = 16'h0000;
        ok    = 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_quest <= qst;
        cmd_unit  <= unit;
        cmd_sel   <= sel;
        cmd_wdata <= (sel == SEL_ENABLE) ? (wdata & ENABLE_MASK) : wdata;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_write <= ~wr;
        cmd_wdata <= ~wdata;
        // The answer pulse stands only in the cycle after the taking edge
        if (!wr) begin
            #1;
            ok    = rd_valid;
            rdata = rd_data;
        end
    endtask
endmodule

// *** test/test_status_event_hierarchy.sv ***
// Self-checking bench for the status and event hierarchy
`timescale 1ns/100ps
module test_status_event_hierarchy;
    import status_event_pkg::*;
    typedef struct packed {
        logic [3:0]  unit;
        logic [15:0] ptr, ntr, c0, c1, ev;
    } row_t;
    logic                           clk, reset_n, queue_not_empty, message_available;
    logic                           status_preset, clear_status_command;
    logic [NUM_INSTR-1:0][OSR_W-1:0] instr_cond;
    logic [SB_W-1:0]                esr_event, status_byte;
    logic                           cmd_valid, cmd_write, cmd_quest, rd_valid;
    logic                           master_summary, service_request;
    logic [UNIT_W-1:0]              cmd_unit;
    reg_sel_t                       cmd_sel;
    logic [OSR_W-1:0]               cmd_wdata, rd_data, r;
    int                             fail_count = 0;
    int                             check_count = 0;
    // Unit, positive filter, negative filter, first condition, second condition, expected event
    row_t rows[4] = '{'{4'h1, 16'h7FFF, 16'h0000, 16'h0000, 16'h0011, 16'h0011},
                      '{4'h2, 16'h0000, 16'h7FFF, 16'h4020, 16'h0000, 16'h4020},
                      '{4'h3, 16'h000F, 16'h0300, 16'h0300, 16'h00FF, 16'h030F},
                      '{4'hE, 16'h7FFF, 16'h7FFF, 16'h2AAA, 16'h5555, 16'h7FFF}};

    status_event_hierarchy u_dut (.clk(clk), .reset_n(reset_n), .instr_cond(instr_cond),
        .esr_event(esr_event), .queue_not_empty(queue_not_empty), .message_available(message_available),
        .status_preset(status_preset), .clear_status_command(clear_status_command),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_quest(cmd_quest), .cmd_unit(cmd_unit),
        .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
        .status_byte(status_byte), .master_summary(master_summary), .service_request(service_request));
    host_ctrl_model u_host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_quest(cmd_quest), .cmd_unit(cmd_unit), .cmd_sel(cmd_sel),
        .cmd_wdata(cmd_wdata));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic qst, input logic [3:0] unit, input reg_sel_t sel, input logic [15:0] d);
        logic [15:0] x;
        logic        ok;
        u_host.access(1'b1, qst, unit, sel, d, x, ok);
    endtask

    // Read with the one-cycle answer pulse checked as well as the data
    task automatic rdc(input logic qst, input logic [3:0] unit, input reg_sel_t sel, input logic [15:0] exp);
        logic ok;
        u_host.access(1'b0, qst, unit, sel, 16'h0000, r, ok);
        check({15'h0000, ok}, 16'h0001);
        check(r, exp);
    endtask

    task automatic pulse_esr(input logic [7:0] v);
        esr_event <= v;
        tick(1);
        esr_event <= 8'h00;
        tick(3);
    endtask

    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        reset_n = 1'b0;
        instr_cond = '0;
        esr_event = 8'h00;
        queue_not_empty = 1'b0;
        message_available = 1'b0;
        status_preset = 1'b0;
        clear_status_command = 1'b0;
        tick(4);
        check({status_byte, 6'h00, master_summary, service_request}, 16'h0000);
        reset_n <= 1'b1;
        rdc(1'b0, 4'h1, SEL_ENABLE, 16'h0000);
        rdc(1'b0, 4'h1, SEL_PTR, 16'h7FFF);
        rdc(1'b0, 4'h0, SEL_STB, 16'h0000);
        rdc(1'b0, 4'h0, SEL_ESR, 16'h0080);
        rdc(1'b0, 4'h0, SEL_ESR, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(1'b0, rows[i].unit, SEL_PTR, rows[i].ptr);
            wr(1'b0, rows[i].unit, SEL_NTR, rows[i].ntr);
            instr_cond[rows[i].unit - 4'h1] <= rows[i].c0;
            tick(3);
            rdc(1'b0, rows[i].unit, SEL_COND, rows[i].c0);
            instr_cond[rows[i].unit - 4'h1] <= rows[i].c1;
            tick(3);
            rdc(1'b0, rows[i].unit, SEL_COND, rows[i].c1);
            rdc(1'b0, rows[i].unit, SEL_EVENT, rows[i].ev);
            rdc(1'b0, rows[i].unit, SEL_EVENT, 16'h0000);
        end
        // Summary chain from instrument five up to the service request
        instr_cond[4] <= 16'h0001;
        tick(3);
        wr(1'b0, 4'h5, SEL_ENABLE, 16'h0002);
        tick(4);
        rdc(1'b0, 4'h0, SEL_COND, 16'h0000);
        wr(1'b0, 4'h5, SEL_ENABLE, 16'hFFFF);
        tick(4);
        rdc(1'b0, 4'h0, SEL_COND, 16'h0020);
        rdc(1'b0, 4'h5, SEL_ENABLE, 16'h7FFF);
        wr(1'b0, 4'h0, SEL_ENABLE, 16'h0020);
        tick(4);
        check({15'h0000, status_byte[7]}, 16'h0001);
        check({15'h0000, master_summary}, 16'h0000);
        wr(1'b0, 4'h0, SEL_SRE, 16'h0080);
        tick(2);
        check({13'h0000, status_byte[6], master_summary, service_request}, 16'h0007);
        rdc(1'b0, 4'h0, SEL_SRE, 16'h0080);
        rdc(1'b0, 4'h0, SEL_SRE, 16'h0080);
        // Preset must spare the service request enable
        status_preset <= 1'b1;
        tick(1);
        status_preset <= 1'b0;
        tick(2);
        rdc(1'b0, 4'h5, SEL_ENABLE, 16'h0000);
        rdc(1'b0, 4'h3, SEL_PTR, 16'h7FFF);
        rdc(1'b0, 4'h3, SEL_NTR, 16'h0000);
        rdc(1'b0, 4'h0, SEL_ENABLE, 16'h0000);
        rdc(1'b0, 4'h0, SEL_SRE, 16'h0080);
        wr(1'b0, 4'h0, SEL_ESE, 16'h0004);
        pulse_esr(8'hFF);
        check({15'h0000, status_byte[5]}, 16'h0001);
        rdc(1'b0, 4'h0, SEL_ESR, 16'h00BD);
        rdc(1'b0, 4'h0, SEL_ESR, 16'h0000);
        pulse_esr(8'h30);
        clear_status_command <= 1'b1;
        tick(1);
        clear_status_command <= 1'b0;
        tick(2);
        rdc(1'b0, 4'h0, SEL_ESR, 16'h0000);
        queue_not_empty <= 1'b1;
        message_available <= 1'b1;
        tick(2);
        check({14'h0000, status_byte[4], status_byte[2]}, 16'h0003);
        check({13'h0000, status_byte[3], status_byte[1:0]}, 16'h0000);
        queue_not_empty <= 1'b0;
        message_available <= 1'b0;
        tick(2);
        wr(1'b0, 4'h0, SEL_ESR, 16'h00FF);
        rdc(1'b0, 4'h0, SEL_STB, 16'h00F4);
        tick(2);
        check({8'h00, status_byte}, 16'h0000);
        wr(1'b1, 4'h1, SEL_ENABLE, 16'h7FFF);
        rdc(1'b1, 4'h1, SEL_ENABLE, 16'h0000);
        rdc(1'b1, 4'h0, SEL_EVENT, 16'h0000);
        report_and_stop();
    end
endmodule
